//--- dpp_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module dpp_ctl_model #(
   parameter int RW = 8
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // Pacing
   input wire logic i_stall,
   // Difference records
   input wire logic i_diff_valid,
   input wire logic [RW-1:0] i_diff_rec,
   output logic o_diff_ready
);
   logic [RW-1:0] recs[$];

   // Ready moves only just after an edge
   always_ff @(posedge i_clk_sys) begin
      o_diff_ready <= i_rst_n && !i_stall;
   end

   // Takes one record per handshake edge
   always @(posedge i_clk_sys) begin
      if (i_rst_n && i_diff_valid && o_diff_ready) begin
         recs.push_back(i_diff_rec);
      end
   end
endmodule : dpp_ctl_model
`default_nettype wire

//--- dpp_dir_alloc.sv
`timescale 1ns/1ps
`default_nettype none
module dpp_dir_alloc
   import dpp_pkg::*;
(
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // Step port
   dpp_step_if.unit st
);
   logic [DPP_POS_W-1:0] next_base_r;
   logic [DPP_POS_W-1:0] free_r;
   logic [DPP_POS_W-1:0] end_r;
   logic open_r;
   logic exh_r;
   logic [DPP_POS_W-1:0] size_b;
   logic [DPP_POS_W-1:0] bits_p;
   logic [DPP_POS_W:0] need_end;
   logic fits_alloc;
   logic fits_na;

   assign size_b = dpp_size_bits(st.size);
   assign bits_p = DPP_POS_W'(st.bits);
   // Own bits within size, at most two bytes
   assign fits_alloc = (size_b != DPP_POS_RST) && (bits_p <= size_b)
                       && (st.bits <= DPP_BITS_W'(DPP_MOD_BITS));
   assign need_end = {1'b0, free_r} + {1'b0, bits_p};
   // Only the newest open, unexhausted section
   assign fits_na = open_r && !exh_r
                    && (need_end <= {1'b0, end_r});
   assign st.total = next_base_r;

   always_comb begin
      st.pos = free_r;
      st.ok = 1'b1;
      st.used = 1'b0;
      case (st.kind)
         DPP_KIND_ALLOC: begin
            st.pos = next_base_r;
            st.ok = fits_alloc;
            st.used = fits_alloc && (st.bits != DPP_BITS_RST);
         end
         DPP_KIND_NONALLOC: begin
            st.pos = free_r;
            st.ok = fits_na;
            st.used = fits_na;
         end
         default: begin
            st.ok = 1'b1;
         end
      endcase
   end

   // Section tracking
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n || st.restart) begin
         next_base_r <= DPP_POS_RST;
         free_r <= DPP_POS_RST;
         end_r <= DPP_POS_RST;
         open_r <= 1'b0;
         exh_r <= 1'b0;
      end else if (st.step) begin
         case (st.kind)
            DPP_KIND_ALLOC: begin
               if (fits_alloc) begin
                  // Spare left after own bits
                  free_r <= next_base_r + bits_p;
                  end_r <= next_base_r + size_b;
                  next_base_r <= next_base_r + size_b;
                  open_r <= 1'b1;
                  exh_r <= 1'b0;
               end else begin
                  open_r <= 1'b0;
               end
            end
            DPP_KIND_NONALLOC: begin
               if (fits_na) begin
                  free_r <= free_r + bits_p;
               end else if (open_r) begin
                  exh_r <= 1'b1;
               end
            end
            default: begin
               open_r <= open_r;
            end
         endcase
      end
   end
endmodule : dpp_dir_alloc
`default_nettype wire

//--- dpp_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module dpp_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 16,
   parameter int AW = $clog2(DEPTH)
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // Fill side
   input wire logic i_wr_valid,
   output logic o_wr_ready,
   input wire logic [W-1:0] i_wr_data,
   // Drain side
   output logic o_rd_valid,
   input wire logic i_rd_ready,
   output logic [W-1:0] o_rd_data
);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic push;
   logic pop;

   assign o_wr_ready = count_r != (AW+1)'(DEPTH);
   assign push = i_wr_valid && o_wr_ready;
   assign pop = (count_r != '0) && (!o_rd_valid || i_rd_ready);

   // Storage
   always_ff @(posedge i_clk_sys) begin
      if (push) begin
         mem[wr_ptr_r] <= i_wr_data;
      end
   end

   // Pointers and fill level
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + AW'(1);
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + AW'(1);
         end
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // Registered output stage
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         o_rd_valid <= 1'b0;
         o_rd_data <= '0;
      end else if (pop) begin
         o_rd_valid <= 1'b1;
         o_rd_data <= mem[rd_ptr_r];
      end else if (i_rd_ready) begin
         o_rd_valid <= 1'b0;
      end
   end
endmodule : dpp_fifo
`default_nettype wire

//--- dpp_packer.sv
`timescale 1ns/1ps
`default_nettype none
module dpp_packer
   import dpp_pkg::*;
#(
   parameter int N_SLOTS = DPP_SLOTS,
   parameter int IMG_BITS = DPP_IMG_BITS,
   parameter int SW = $clog2(N_SLOTS)
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,

   // Configured layout
   input wire logic i_cfg_we,
   input wire logic [SW-1:0] i_cfg_slot,
   input wire logic [DPP_TYPE_W-1:0] i_cfg_type,
   input wire dpp_kind_t i_cfg_kind_in,
   input wire dpp_kind_t i_cfg_kind_out,
   input wire logic [DPP_BITS_W-1:0] i_cfg_bits_in,
   input wire logic [DPP_BITS_W-1:0] i_cfg_bits_out,
   input wire dpp_size_t i_cfg_size_in,
   input wire dpp_size_t i_cfg_size_out,

   // Inserted modules
   input wire logic i_phys_we,
   input wire logic [SW-1:0] i_phys_slot,
   input wire logic [DPP_TYPE_W-1:0] i_phys_type,

   // Connection control
   input wire logic i_connect,
   input wire logic i_release,
   output logic o_busy,
   output logic o_done,
   output logic o_active,
   output logic [DPP_POS_W-1:0] o_in_len,
   output logic [DPP_POS_W-1:0] o_out_len,

   // Module difference records
   output logic o_diff_valid,
   input wire logic i_diff_ready,
   output logic [SW+3:0] o_diff_rec,

   // Process images
   input wire logic [IMG_BITS-1:0] i_out_img,
   output logic [IMG_BITS-1:0] o_in_img,

   // Local module data
   input wire logic [N_SLOTS*DPP_MOD_BITS-1:0] i_mod_in,
   output logic [N_SLOTS*DPP_MOD_BITS-1:0] o_mod_out
);
   // Configuration memory
   logic [DPP_TYPE_W-1:0] cfg_type_r [N_SLOTS];
   dpp_kind_t cfg_kind_in_r [N_SLOTS];
   dpp_kind_t cfg_kind_out_r [N_SLOTS];
   logic [DPP_BITS_W-1:0] cfg_bits_in_r [N_SLOTS];
   logic [DPP_BITS_W-1:0] cfg_bits_out_r [N_SLOTS];
   dpp_size_t cfg_size_in_r [N_SLOTS];
   dpp_size_t cfg_size_out_r [N_SLOTS];
   logic [DPP_TYPE_W-1:0] phys_type_r [N_SLOTS];

   // Placement tables
   logic [DPP_POS_W-1:0] in_pos_r [N_SLOTS];
   logic [DPP_POS_W-1:0] out_pos_r [N_SLOTS];
   logic [DPP_BITS_W-1:0] in_bits_r [N_SLOTS];
   logic [DPP_BITS_W-1:0] out_bits_r [N_SLOTS];
   logic in_use_r [N_SLOTS];
   logic out_use_r [N_SLOTS];

   // Walk control
   dpp_state_t state_r;
   logic [SW-1:0] slot_r;
   logic mism;
   logic bad;
   logic need;
   logic adv;
   logic walk;
   logic last;
   logic fifo_ready;
   logic [SW+3:0] rec;
   dpp_mstat_t rec_ms;
   dpp_sstat_t rec_ss;

   // Data path
   logic [IMG_BITS-1:0] in_part [N_SLOTS];
   logic [IMG_BITS-1:0] in_img_nxt;
   logic [N_SLOTS*DPP_MOD_BITS-1:0] mod_out_nxt;

   dpp_step_if in_if ();
   dpp_step_if out_if ();

   // Configuration writes
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         for (int i = 0; i < N_SLOTS; i++) begin
            cfg_type_r[i] <= DPP_TYPE_RST;
            cfg_kind_in_r[i] <= DPP_KIND_NONE;
            cfg_kind_out_r[i] <= DPP_KIND_NONE;
            cfg_bits_in_r[i] <= DPP_BITS_RST;
            cfg_bits_out_r[i] <= DPP_BITS_RST;
            cfg_size_in_r[i] <= DPP_SZ_NONE;
            cfg_size_out_r[i] <= DPP_SZ_NONE;
         end
      end else if (i_cfg_we) begin
         cfg_type_r[i_cfg_slot] <= i_cfg_type;
         cfg_kind_in_r[i_cfg_slot] <= i_cfg_kind_in;
         cfg_kind_out_r[i_cfg_slot] <= i_cfg_kind_out;
         cfg_bits_in_r[i_cfg_slot] <= i_cfg_bits_in;
         cfg_bits_out_r[i_cfg_slot] <= i_cfg_bits_out;
         cfg_size_in_r[i_cfg_slot] <= i_cfg_size_in;
         cfg_size_out_r[i_cfg_slot] <= i_cfg_size_out;
      end
   end

   // Inserted module types
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         for (int i = 0; i < N_SLOTS; i++) begin
            phys_type_r[i] <= DPP_TYPE_RST;
         end
      end else if (i_phys_we) begin
         phys_type_r[i_phys_slot] <= i_phys_type;
      end
   end

   // Current slot check
   assign walk = state_r == DPP_ST_WALK;
   assign last = slot_r == SW'(N_SLOTS - 1);
   assign mism = cfg_type_r[slot_r] != phys_type_r[slot_r];
   assign bad = !mism && (!in_if.ok || !out_if.ok);
   assign need = mism || bad;
   assign adv = walk && (!need || fifo_ready);
   assign rec_ms = mism ? DPP_MS_SUBST : DPP_MS_PROPER;
   assign rec_ss = DPP_SS_WRONG;
   assign rec = {slot_r, rec_ms, rec_ss};

   // Step ports, input and output kept apart
   assign in_if.restart = i_connect;
   assign out_if.restart = i_connect;
   assign in_if.step = adv;
   assign out_if.step = adv;
   assign in_if.kind = mism ? DPP_KIND_NONE : cfg_kind_in_r[slot_r];
   assign out_if.kind = mism ? DPP_KIND_NONE : cfg_kind_out_r[slot_r];
   assign in_if.bits = cfg_bits_in_r[slot_r];
   assign out_if.bits = cfg_bits_out_r[slot_r];
   assign in_if.size = cfg_size_in_r[slot_r];
   assign out_if.size = cfg_size_out_r[slot_r];

   dpp_dir_alloc u_in_alloc (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .st(in_if)
   );

   dpp_dir_alloc u_out_alloc (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .st(out_if)
   );

   dpp_fifo #(
      .W(SW + 4),
      .DEPTH(DPP_FIFO_DEPTH)
   ) u_diff_fifo (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_wr_valid(walk && need),
      .o_wr_ready(fifo_ready),
      .i_wr_data(rec),
      .o_rd_valid(o_diff_valid),
      .i_rd_ready(i_diff_ready),
      .o_rd_data(o_diff_rec)
   );

   // Connection walk
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         state_r <= DPP_ST_IDLE;
         slot_r <= '0;
      end else if (i_connect) begin
         state_r <= DPP_ST_WALK;
         slot_r <= '0;
      end else begin
         case (state_r)
            DPP_ST_IDLE: begin
               slot_r <= '0;
            end
            DPP_ST_WALK: begin
               if (adv) begin
                  slot_r <= slot_r + SW'(1);
                  if (last) begin
                     state_r <= DPP_ST_DONE;
                  end
               end
            end
            DPP_ST_DONE: begin
               state_r <= DPP_ST_IDLE;
            end
            default: begin
               state_r <= DPP_ST_IDLE;
            end
         endcase
      end
   end

   // Placement table update
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         for (int i = 0; i < N_SLOTS; i++) begin
            in_pos_r[i] <= DPP_POS_RST;
            out_pos_r[i] <= DPP_POS_RST;
            in_bits_r[i] <= DPP_BITS_RST;
            out_bits_r[i] <= DPP_BITS_RST;
            in_use_r[i] <= 1'b0;
            out_use_r[i] <= 1'b0;
         end
      end else if (adv) begin
         in_pos_r[slot_r] <= in_if.pos;
         out_pos_r[slot_r] <= out_if.pos;
         in_bits_r[slot_r] <= cfg_bits_in_r[slot_r];
         out_bits_r[slot_r] <= cfg_bits_out_r[slot_r];
         in_use_r[slot_r] <= !mism && in_if.used;
         out_use_r[slot_r] <= !mism && out_if.used;
      end
   end

   // Connection status
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         o_busy <= 1'b0;
         o_done <= 1'b0;
         o_active <= 1'b0;
         o_in_len <= DPP_POS_RST;
         o_out_len <= DPP_POS_RST;
      end else begin
         o_busy <= i_connect || (walk && !(adv && last));
         o_done <= walk && adv && last && !i_connect;
         // Completion beats a release in the same cycle
         if (walk && adv && last && !i_connect) begin
            o_active <= 1'b1;
         end else if (i_connect || i_release) begin
            o_active <= 1'b0;
         end
         if (walk && adv && last) begin
            o_in_len <= in_if.total;
            o_out_len <= out_if.total;
         end
      end
   end

   // Per slot packing and unpacking
   for (genvar g = 0; g < N_SLOTS; g++) begin : g_slot
      logic [DPP_MOD_BITS-1:0] in_bits_g;
      logic [IMG_BITS-1:0] out_sh;
      logic [DPP_MOD_BITS-1:0] out_mask;

      assign in_bits_g = i_mod_in[g*DPP_MOD_BITS +: DPP_MOD_BITS]
                         & dpp_mask(in_bits_r[g]);
      assign in_part[g] = (o_active && in_use_r[g])
                          ? (IMG_BITS'(in_bits_g) << in_pos_r[g])
                          : '0;
      assign out_sh = i_out_img >> out_pos_r[g];
      assign out_mask = (o_active && out_use_r[g])
                        ? dpp_mask(out_bits_r[g]) : '0;
      assign mod_out_nxt[g*DPP_MOD_BITS +: DPP_MOD_BITS] =
         out_sh[DPP_MOD_BITS-1:0] & out_mask;
   end

   // Input image merge, free bits stay zero
   always_comb begin
      in_img_nxt = '0;
      for (int i = 0; i < N_SLOTS; i++) begin
         in_img_nxt = in_img_nxt | in_part[i];
      end
   end

   // Image outputs
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         o_in_img <= '0;
         o_mod_out <= '0;
      end else begin
         o_in_img <= in_img_nxt;
         o_mod_out <= mod_out_nxt;
      end
   end
endmodule : dpp_packer
`default_nettype wire

//--- dpp_packer_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dpp_packer_chk
   import dpp_pkg::*;
#(
   parameter int N_SLOTS = DPP_SLOTS,
   parameter int IMG_BITS = DPP_IMG_BITS,
   parameter int SW = $clog2(N_SLOTS)
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // Control
   input wire logic i_connect,
   input wire logic i_release,
   input wire logic i_diff_ready,
   // Status and data
   input wire logic o_busy,
   input wire logic o_done,
   input wire logic o_active,
   input wire logic [DPP_POS_W-1:0] o_in_len,
   input wire logic [DPP_POS_W-1:0] o_out_len,
   input wire logic o_diff_valid,
   input wire logic [SW+3:0] o_diff_rec,
   input wire logic [IMG_BITS-1:0] o_in_img,
   input wire logic [N_SLOTS*DPP_MOD_BITS-1:0] o_mod_out
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_n);

   a_walk_busy: assert property (i_connect |=> o_busy)
      else $error("walk not busy after connect");
   a_walk_min: assert property (i_connect |=> !o_done [*8])
      else $error("walk ended too early");
   a_walk_bound: assert property (i_connect |-> ##[1:400] o_done)
      else $error("walk never ended");
   a_done_state: assert property (o_done |-> o_active && !o_busy)
      else $error("done without active state");
   a_walk_inactive: assert property (o_busy |-> !o_active)
      else $error("active during walk");
   a_rec_hold: assert property (o_diff_valid && !i_diff_ready &&
      !i_connect |=> o_diff_valid && $stable(o_diff_rec))
      else $error("record dropped under back-pressure");
   a_rec_wrong: assert property (o_diff_valid |->
      o_diff_rec[1:0] == 2'h1 && o_diff_rec[3:2] <= 2'h1)
      else $error("bad record status");
   a_len_load: assert property (!o_done |->
      $stable(o_in_len) && $stable(o_out_len))
      else $error("length moved outside walk end");
   a_len_bytes: assert property (o_done |->
      o_in_len[2:0] == 3'h0 && o_out_len[2:0] == 3'h0)
      else $error("length not whole bytes");
   a_release_off: assert property (i_release && !o_busy &&
      !i_connect |=> !o_active)
      else $error("release kept active");
   a_idle_zero: assert property (!o_active &&
      $past(o_active) == 1'b0 |-> o_in_img == '0 && o_mod_out == '0)
      else $error("image live while inactive");

   cp_done: cover property (o_done);
   cp_stall: cover property (o_diff_valid && !i_diff_ready);
   cp_take: cover property (o_diff_valid && i_diff_ready);
endmodule : dpp_packer_chk

bind dpp_packer dpp_packer_chk #(.N_SLOTS(N_SLOTS), .IMG_BITS(IMG_BITS),
   .SW(SW)) u_chk (.i_clk_sys, .i_rst_n, .i_connect, .i_release,
   .i_diff_ready, .o_busy, .o_done, .o_active, .o_in_len, .o_out_len,
   .o_diff_valid, .o_diff_rec, .o_in_img, .o_mod_out);
`default_nettype wire

//--- dpp_packer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dpp_packer_tb;
   import dpp_pkg::*;
   localparam int SW = 4;
   localparam dpp_kind_t k_no = DPP_KIND_NONE;
   localparam dpp_kind_t k_an = DPP_KIND_ANALOG;
   localparam dpp_kind_t k_al = DPP_KIND_ALLOC;
   localparam dpp_kind_t k_na = DPP_KIND_NONALLOC;
   localparam logic [7:0] exp_rec [3] = '{8'h41, 8'h51, 8'h75};
   logic i_clk_sys, i_rst_n, i_cfg_we, i_phys_we, i_connect, i_release;
   logic [SW-1:0] i_cfg_slot, i_phys_slot;
   logic [DPP_TYPE_W-1:0] i_cfg_type, i_phys_type;
   dpp_kind_t i_cfg_kind_in, i_cfg_kind_out;
   logic [DPP_BITS_W-1:0] i_cfg_bits_in, i_cfg_bits_out;
   dpp_size_t i_cfg_size_in, i_cfg_size_out;
   logic o_busy, o_done, o_active, o_diff_valid, i_diff_ready, stall;
   logic [DPP_POS_W-1:0] o_in_len, o_out_len;
   logic [SW+3:0] o_diff_rec;
   logic [DPP_IMG_BITS-1:0] i_out_img, o_in_img, exp_in;
   logic [DPP_SLOTS*DPP_MOD_BITS-1:0] i_mod_in, o_mod_out, exp_out;
   int n_fail = 0;
   int comparisons = 0;

   dpp_packer u_dut (.i_clk_sys, .i_rst_n, .i_cfg_we, .i_cfg_slot,
      .i_cfg_type, .i_cfg_kind_in, .i_cfg_kind_out, .i_cfg_bits_in,
      .i_cfg_bits_out, .i_cfg_size_in, .i_cfg_size_out, .i_phys_we,
      .i_phys_slot, .i_phys_type, .i_connect, .i_release, .o_busy,
      .o_done, .o_active, .o_in_len, .o_out_len, .o_diff_valid,
      .i_diff_ready, .o_diff_rec, .i_out_img, .o_in_img, .i_mod_in,
      .o_mod_out);

   dpp_ctl_model u_ctl (.i_clk_sys, .i_rst_n, .i_stall(stall),
      .i_diff_valid(o_diff_valid), .i_diff_rec(o_diff_rec),
      .o_diff_ready(i_diff_ready));

   initial begin
      i_clk_sys = 1'b0;
      forever #2.5 i_clk_sys = ~i_clk_sys;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask : tick

   task automatic check(input logic [DPP_IMG_BITS-1:0] seen, exp,
         input string what);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t %s", $time, what);
      end
   endtask : check

   // Write strobes stay up between back-to-back entries
   task automatic cfg(input int s, input dpp_kind_t ki, ko,
         input int bi, bo, input dpp_size_t zi, zo, input bit mis);
      i_cfg_we = 1'b1;
      i_phys_we = 1'b1;
      i_cfg_slot = s[SW-1:0];
      i_phys_slot = s[SW-1:0];
      i_cfg_type = 8'h30 + 8'(s);
      i_phys_type = mis ? 8'hEE : 8'h30 + 8'(s);
      i_cfg_kind_in = ki;
      i_cfg_kind_out = ko;
      i_cfg_bits_in = bi[DPP_BITS_W-1:0];
      i_cfg_bits_out = bo[DPP_BITS_W-1:0];
      i_cfg_size_in = zi;
      i_cfg_size_out = zo;
      tick(1);
   endtask : cfg

   task automatic clear_cfg();
      for (int s = 0; s < DPP_SLOTS; s++) begin
         cfg(s, k_no, k_no, 0, 0, DPP_SZ_NONE, DPP_SZ_NONE, 0);
      end
   endtask : clear_cfg

   task automatic connect_walk();
      int n;
      i_cfg_we = 1'b0;
      i_phys_we = 1'b0;
      u_ctl.recs.delete();
      tick(1);
      i_connect = 1'b1;
      tick(1);
      i_connect = 0;
      check(o_busy, 1'b1, "busy after connect");
      n = 0;
      while (o_done !== 1'b1 && n < 300) begin
         tick(1);
         n++;
      end
      check(o_done, 1'b1, "walk end");
      check(o_active, 1'b1, "active at end");
   endtask : connect_walk

   task automatic test_pack();
      clear_cfg();
      cfg(1, k_al, k_no, 2, 0, DPP_SZ_16, DPP_SZ_NONE, 0);
      cfg(2, k_no, k_al, 0, 4, DPP_SZ_NONE, DPP_SZ_16, 0);
      cfg(3, k_an, k_an, 0, 0, DPP_SZ_NONE, DPP_SZ_NONE, 0);
      cfg(4, k_no, k_na, 0, 8, DPP_SZ_NONE, DPP_SZ_NONE, 0);
      cfg(5, k_na, k_no, 4, 0, DPP_SZ_NONE, DPP_SZ_NONE, 0);
      cfg(6, k_no, k_al, 0, 2, DPP_SZ_NONE, DPP_SZ_8, 0);
      cfg(7, k_no, k_na, 0, 4, DPP_SZ_NONE, DPP_SZ_NONE, 0);
      for (int s = 0; s < DPP_SLOTS; s++) begin
         i_mod_in[s*16 +: 16] = 16'(s * 16'h1F35 + 16'h0A69);
      end
      i_out_img = {16{32'hC3A596E1}};
      connect_walk();
      check(o_in_len, 10'h010, "in length");
      check(o_out_len, 10'h018, "out length");
      exp_in = '0;
      exp_in[1:0] = i_mod_in[17:16];
      exp_in[5:2] = i_mod_in[83:80];
      exp_out = '0;
      exp_out[35:32] = i_out_img[3:0];
      exp_out[71:64] = i_out_img[11:4];
      exp_out[97:96] = i_out_img[17:16];
      exp_out[115:112] = i_out_img[21:18];
      tick(5);
      check(o_in_img, exp_in, "in image");
      check(o_mod_out, exp_out, "module outputs");
      check(u_ctl.recs.size(), 0, "no records");
   endtask : test_pack

   task automatic test_exhaust();
      clear_cfg();
      cfg(0, k_al, k_no, 2, 0, DPP_SZ_16, DPP_SZ_NONE, 0);
      for (int s = 1; s < 6; s++) begin
         cfg(s, k_na, k_no, 4, 0, DPP_SZ_NONE, DPP_SZ_NONE, 0);
      end
      cfg(7, k_no, k_al, 0, 4, DPP_SZ_NONE, DPP_SZ_8, 1);
      cfg(8, k_al, k_no, 4, 0, DPP_SZ_32, DPP_SZ_NONE, 0);
      cfg(9, k_na, k_no, 2, 0, DPP_SZ_NONE, DPP_SZ_NONE, 0);
      i_mod_in = '1;
      i_out_img = '1;
      stall = 1'b1;
      connect_walk();
      check(o_in_len, 10'h030, "in length");
      check(o_out_len, 10'h000, "out length");
      check(o_diff_valid, 1'b1, "record held");
      stall = 1'b0;
      tick(12);
      check(o_in_img, 512'h3F3FFF, "in image");
      check(o_mod_out, '0, "module outputs");
      check(u_ctl.recs.size(), 3, "record count");
      for (int i = 0; i < 3 && i < u_ctl.recs.size(); i++) begin
         check(u_ctl.recs[i], exp_rec[i], "record");
      end
   endtask : test_exhaust

   task automatic test_release();
      i_release = 1'b1;
      tick(1);
      i_release = 1'b0;
      tick(2);
      check(o_active, 1'b0, "active after release");
      check(o_in_img, '0, "image after release");
   endtask : test_release

   task automatic complete_run();
      if (n_fail == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : complete_run

   initial begin
      repeat (5000) @(posedge i_clk_sys);
      n_fail++;
      complete_run();
   end

   initial begin
      i_rst_n = 1'b0;
      {i_cfg_we, i_phys_we, i_connect, i_release, stall} = 5'h00;
      {i_cfg_slot, i_phys_slot, i_cfg_type, i_phys_type} = '0;
      i_cfg_kind_in = k_no;
      i_cfg_kind_out = k_no;
      {i_cfg_bits_in, i_cfg_bits_out} = '0;
      i_cfg_size_in = DPP_SZ_NONE;
      i_cfg_size_out = DPP_SZ_NONE;
      i_out_img = '0;
      i_mod_in = '0;
      tick(3);
      check({o_busy, o_done, o_active, o_diff_valid}, 4'h0, "reset");
      i_rst_n = 1'b1;
      test_pack();
      test_exhaust();
      test_release();
      complete_run();
   end
endmodule : dpp_packer_tb
`default_nettype wire

//--- dpp_pkg.sv
package dpp_pkg;

   // Sizes
   localparam int DPP_SLOTS = 16;
   localparam int DPP_MOD_BITS = 16;
   localparam int DPP_BITS_W = 5;
   localparam int DPP_IMG_BITS = 512;
   localparam int DPP_POS_W = 10;
   localparam int DPP_TYPE_W = 8;
   localparam int DPP_FIFO_DEPTH = 16;

   // Section sizes in bits
   localparam logic [DPP_POS_W-1:0] DPP_SEC_8 = 10'h008;
   localparam logic [DPP_POS_W-1:0] DPP_SEC_16 = 10'h010;
   localparam logic [DPP_POS_W-1:0] DPP_SEC_32 = 10'h020;

   // Reset values
   localparam logic [DPP_POS_W-1:0] DPP_POS_RST = 10'h000;
   localparam logic [DPP_TYPE_W-1:0] DPP_TYPE_RST = 8'h00;
   localparam logic [DPP_BITS_W-1:0] DPP_BITS_RST = 5'h00;

   typedef enum logic [1:0] {
      DPP_KIND_NONE = 2'h0,
      DPP_KIND_ANALOG = 2'h1,
      DPP_KIND_ALLOC = 2'h2,
      DPP_KIND_NONALLOC = 2'h3
   } dpp_kind_t;

   typedef enum logic [1:0] {
      DPP_SZ_NONE = 2'h0,
      DPP_SZ_8 = 2'h1,
      DPP_SZ_16 = 2'h2,
      DPP_SZ_32 = 2'h3
   } dpp_size_t;

   typedef enum logic [1:0] {
      DPP_MS_PROPER = 2'h0,
      DPP_MS_SUBST = 2'h1
   } dpp_mstat_t;

   typedef enum logic [1:0] {
      DPP_SS_OK = 2'h0,
      DPP_SS_WRONG = 2'h1
   } dpp_sstat_t;

   typedef enum logic [1:0] {
      DPP_ST_IDLE = 2'h0,
      DPP_ST_WALK = 2'h1,
      DPP_ST_DONE = 2'h2
   } dpp_state_t;

   function automatic logic [DPP_MOD_BITS-1:0] dpp_mask(
      input logic [DPP_BITS_W-1:0] n);
      logic [DPP_MOD_BITS:0] m;
      m = (17'h00001 << n) - 17'h00001;
      return m[DPP_MOD_BITS-1:0];
   endfunction : dpp_mask

   function automatic logic [DPP_POS_W-1:0] dpp_size_bits(
      input dpp_size_t s);
      case (s)
         DPP_SZ_8: return DPP_SEC_8;
         DPP_SZ_16: return DPP_SEC_16;
         DPP_SZ_32: return DPP_SEC_32;
         default: return DPP_POS_RST;
      endcase
   endfunction : dpp_size_bits

endpackage : dpp_pkg

//--- dpp_step_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dpp_step_if;
   import dpp_pkg::*;
   logic restart;
   logic step;
   dpp_kind_t kind;
   logic [DPP_BITS_W-1:0] bits;
   dpp_size_t size;
   logic [DPP_POS_W-1:0] pos;
   logic ok;
   logic used;
   logic [DPP_POS_W-1:0] total;
   modport ctrl (output restart, step, kind, bits, size,
                 input pos, ok, used, total);
   modport unit (input restart, step, kind, bits, size,
                 output pos, ok, used, total);
endinterface : dpp_step_if
`default_nettype wire
